//--- rtl/power_mode_controller.sv
// Power mode controller: clock gating, power domains and wake-up.
`timescale 1ns/1ps
`include "power_mode_params.svh"
module power_mode_controller
   import power_mode_pkg::*;
#(
   parameter int NP = `PMC_NUM_PERIPH,
   parameter int NA = `PMC_NUM_ANALOG
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic enter_i,
   input wire logic [1:0] mode_req_i,
   input wire logic irq_i,
   input wire logic [NP-1:0] periph_clk_en_i,
   input wire logic [NP-1:0] periph_pwr_en_i,
   input wire logic [NA-1:0] analog_en_i,
   input wire logic [NP-1:0] deep_keep_i,
   input wire logic [NA-1:0] analog_keep_i,
   input wire logic fro_keep_i,
   input wire logic dma_deep_en_i,
   input wire logic usart_sync_slave_i,
   input wire logic usart_32k_i,
   input wire logic spi_slave_i,
   input wire logic i2c_slave_i,
   input wire logic [NP-1:0] wake_src_i,
   input wire logic rtc_alarm_flag_i,
   input wire logic reset_pin_n_i,
   output pmc_state_e mode_o,
   output logic cpu_clk_en_o,
   output logic main_clk_en_o,
   output logic [NP-1:0] periph_clk_en_o,
   output logic [NP-1:0] periph_pwr_en_o,
   output logic [NA-1:0] analog_pwr_en_o,
   output logic fro_en_o,
   output logic flash_standby_o,
   output logic dma_en_o,
   output logic retain_o,
   output logic pin_hold_o,
   output logic pin_tristate_o,
   output logic core_pwr_en_o,
   output logic chip_reset_o,
   output logic rtc_wake_req_o
);

   ////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   // Fixed slot indices need at least the documented number of slots
   if (NP < `PMC_NUM_PERIPH || NA < `PMC_NUM_ANALOG)
   begin : g_bad_size
      $error("power_mode_controller: too few peripheral or analog slots");
   end

   localparam logic [`PMC_CNT_W-1:0] RST_CYC =
      `PMC_CNT_W'(`PMC_RST_CYCLES);

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for inputs from other domains

   logic [NP-1:0] wake_s; // Synchronised peripheral wake requests
   logic alarm_s; // Synchronised one-hertz alarm flag
   logic rst_pin_n_s; // Synchronised reset pin, low means asserted

   // One filter per wake line; these come from unclocked blocks
   for (genvar i = 0; i < NP; i++)
   begin : g_wake_sync
      pin_sync #(.RESET_VAL(1'b0)) u_sync (
         .clock_i(clock_i),
         .sys_rst_i(sys_rst_i),
         .async_i(wake_src_i[i]),
         .sync_o(wake_s[i])
      );
   end

   // Alarm flag lives in the always-on RTC domain
   pin_sync #(.RESET_VAL(1'b0)) u_alarm_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .async_i(rtc_alarm_flag_i),
      .sync_o(alarm_s)
   );

   // Reset pin idles high
   pin_sync #(.RESET_VAL(1'b1)) u_rst_sync (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .async_i(reset_pin_n_i),
      .sync_o(rst_pin_n_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // Wake qualification

   logic [NP-1:0] deep_wake_ok; // Wake lines allowed in deep-sleep
   logic deep_wake; // Any qualified deep-sleep wake
   logic rst_pin; // Reset pin asserted

   // Serial units are unclocked in deep-sleep, so only the modes that
   // run from the far party's clock can still signal a wake
   always_comb
   begin
      deep_wake_ok = wake_s & deep_keep_i; // [R8]
      deep_wake_ok[`PMC_P_USART] = wake_s[`PMC_P_USART]
         & deep_keep_i[`PMC_P_USART]
         & (usart_sync_slave_i | usart_32k_i); // [R9]
      deep_wake_ok[`PMC_P_SPI] = wake_s[`PMC_P_SPI]
         & deep_keep_i[`PMC_P_SPI] & spi_slave_i; // [R10]
      deep_wake_ok[`PMC_P_I2C] = wake_s[`PMC_P_I2C]
         & deep_keep_i[`PMC_P_I2C] & i2c_slave_i; // [R10]
   end

   assign deep_wake = (|deep_wake_ok) | alarm_s;
   assign rst_pin = ~rst_pin_n_s;

   ////////////////////////////////////////////////////////////////////////
   // State

   // All state in one record; outputs are its fields
   typedef struct packed
   {
      pmc_state_e state;
      logic [`PMC_CNT_W-1:0] cnt;
      logic cpu_clk;
      logic main_clk;
      logic [NP-1:0] pclk;
      logic [NP-1:0] ppwr;
      logic [NA-1:0] apwr;
      logic fro;
      logic flash_sb;
      logic dma;
      logic retain;
      logic hold;
      logic tri_pins;
      logic core_pwr;
      logic chip_rst;
      logic rtc_wake;
   } pmc_s;

   pmc_s cur_q;
   pmc_s nxt_d;

   // Next state and next outputs
   always_comb
   begin
      nxt_d = cur_q;
      nxt_d.cnt = '0;
      nxt_d.rtc_wake = alarm_s; // [R14]
      unique case (cur_q.state)
         ST_ACTIVE:
         begin
            // Enter the requested reduced mode on the processor's cue
            if (enter_i && mode_req_i == `PMC_REQ_SLEEP)
            begin
               nxt_d.state = ST_SLEEP;
            end
            else if (enter_i && mode_req_i == `PMC_REQ_DEEP_SLEEP)
            begin
               nxt_d.state = ST_DEEP_SLEEP;
            end
            else if (enter_i && mode_req_i == `PMC_REQ_POWER_DOWN)
            begin
               nxt_d.state = ST_POWER_DOWN;
            end
         end
         ST_SLEEP:
         begin
            // Any interrupt from a clocked peripheral resumes
            if (irq_i)
            begin
               nxt_d.state = ST_ACTIVE; // [R2] [R3]
            end
         end
         ST_DEEP_SLEEP:
         begin
            // Only sources kept alive may end deep-sleep
            if (deep_wake)
            begin
               nxt_d.state = ST_ACTIVE; // [R8]
            end
         end
         ST_POWER_DOWN:
         begin
            // Nothing was kept, so the alarm leads to a full reset
            if (alarm_s)
            begin
               nxt_d.state = ST_RESET_SEQ; // [R13] [R16]
            end
         end
         ST_RESET_SEQ:
         begin
            // Hold chip reset for the whole sequence length
            if (cur_q.cnt >= RST_CYC - `PMC_CNT_W'(1))
            begin
               nxt_d.state = ST_ACTIVE; // [R16]
            end
            else
            begin
               nxt_d.cnt = cur_q.cnt + `PMC_CNT_W'(1);
            end
         end
         default:
         begin
            nxt_d.state = ST_RESET_SEQ;
         end
      endcase

      // Reset pin wins from any state; it is the only other exit
      if (rst_pin)
      begin
         nxt_d.state = ST_RESET_SEQ; // [R2] [R13]
         nxt_d.cnt = '0;
      end

      // Outputs follow the next state, so they change with it
      nxt_d.cpu_clk = 1'b0;
      nxt_d.main_clk = 1'b0;
      nxt_d.pclk = '0;
      nxt_d.ppwr = '0;
      nxt_d.apwr = '0;
      nxt_d.fro = 1'b0;
      nxt_d.flash_sb = 1'b0;
      nxt_d.dma = 1'b0;
      nxt_d.retain = 1'b0;
      nxt_d.hold = 1'b0;
      nxt_d.tri_pins = 1'b0;
      nxt_d.core_pwr = 1'b1;
      nxt_d.chip_rst = 1'b0;
      unique case (nxt_d.state)
         ST_ACTIVE:
         begin
            nxt_d.cpu_clk = 1'b1;
            nxt_d.main_clk = 1'b1;
            nxt_d.pclk = periph_clk_en_i; // [R1]
            nxt_d.ppwr = periph_pwr_en_i; // [R1]
            nxt_d.apwr = analog_en_i;
            nxt_d.fro = 1'b1;
            nxt_d.dma = 1'b1;
            nxt_d.retain = 1'b1;
         end
         ST_SLEEP:
         begin
            // Only the processor clock stops
            nxt_d.main_clk = 1'b1;
            nxt_d.pclk = periph_clk_en_i; // [R3]
            nxt_d.ppwr = periph_pwr_en_i;
            nxt_d.apwr = analog_en_i;
            nxt_d.fro = 1'b1;
            nxt_d.dma = 1'b1; // [R11]
            nxt_d.retain = 1'b1; // [R4]
            nxt_d.hold = 1'b1; // [R4]
         end
         ST_DEEP_SLEEP:
         begin
            // Clocks stay gated; kept blocks run from their own oscillator
            nxt_d.ppwr = periph_pwr_en_i & deep_keep_i; // [R5] [R8]
            nxt_d.apwr = analog_keep_i; // [R7]
            nxt_d.fro = fro_keep_i; // [R5]
            nxt_d.flash_sb = 1'b1; // [R6]
            nxt_d.dma = dma_deep_en_i; // [R11]
            nxt_d.retain = 1'b1; // [R4]
            nxt_d.hold = 1'b1; // [R4]
         end
         ST_POWER_DOWN:
         begin
            // Core supply removed; only the RTC domain survives
            nxt_d.ppwr[`PMC_P_RTC] = 1'b1; // [R12]
            nxt_d.core_pwr = 1'b0; // [R12]
            nxt_d.tri_pins = 1'b1; // [R15]
         end
         ST_RESET_SEQ:
         begin
            // Retention already lost; pins float until released
            nxt_d.chip_rst = 1'b1; // [R16]
            nxt_d.tri_pins = 1'b1;
         end
         default:
         begin
            nxt_d.chip_rst = 1'b1;
         end
      endcase
   end

   // State register; reset starts the chip in its reset sequence
   always_ff @(posedge clock_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cur_q <= '0;
         cur_q.state <= ST_RESET_SEQ;
         cur_q.chip_rst <= 1'b1;
         cur_q.tri_pins <= 1'b1;
         cur_q.core_pwr <= 1'b1;
      end
      else
      begin
         cur_q <= nxt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign mode_o = cur_q.state;
   assign cpu_clk_en_o = cur_q.cpu_clk;
   assign main_clk_en_o = cur_q.main_clk;
   assign periph_clk_en_o = cur_q.pclk;
   assign periph_pwr_en_o = cur_q.ppwr;
   assign analog_pwr_en_o = cur_q.apwr;
   assign fro_en_o = cur_q.fro;
   assign flash_standby_o = cur_q.flash_sb;
   assign dma_en_o = cur_q.dma;
   assign retain_o = cur_q.retain;
   assign pin_hold_o = cur_q.hold;
   assign pin_tristate_o = cur_q.tri_pins;
   assign core_pwr_en_o = cur_q.core_pwr;
   assign chip_reset_o = cur_q.chip_rst;
   assign rtc_wake_req_o = cur_q.rtc_wake;

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   a_active_pclk: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (mode_o == ST_ACTIVE && $past(mode_o) == ST_ACTIVE)
      |-> periph_clk_en_o == $past(periph_clk_en_i)) // [R1]
      else $error("active peripheral clocks do not follow enables");

   a_sleep_entry: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (mode_o == ST_ACTIVE && enter_i && mode_req_i == `PMC_REQ_SLEEP
       && rst_pin_n_s)
      |=> mode_o == ST_SLEEP && !cpu_clk_en_o && main_clk_en_o) // [R2]
      else $error("sleep entry did not stop only the processor clock");

   a_sleep_irq_wake: assert property (@(posedge clock_i)
      disable iff (sys_rst_i)
      (mode_o == ST_SLEEP && irq_i && rst_pin_n_s)
      |=> mode_o == ST_ACTIVE && cpu_clk_en_o) // [R3]
      else $error("interrupt in sleep did not resume processor");

   a_low_retain: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (mode_o == ST_SLEEP || mode_o == ST_DEEP_SLEEP)
      |-> retain_o && pin_hold_o && !pin_tristate_o) // [R4]
      else $error("retention or pin hold lost in sleep");

   a_deep_gating: assert property (@(posedge clock_i)
      disable iff (sys_rst_i)
      mode_o == ST_DEEP_SLEEP |-> !cpu_clk_en_o && !main_clk_en_o
      && periph_clk_en_o == '0 && flash_standby_o
      && fro_en_o == $past(fro_keep_i)) // [R5]
      else $error("deep-sleep clock or flash gating wrong");

   a_deep_analog: assert property (@(posedge clock_i)
      disable iff (sys_rst_i)
      mode_o == ST_DEEP_SLEEP
      |-> analog_pwr_en_o == $past(analog_keep_i)) // [R7]
      else $error("deep-sleep analog power not as kept");

   // Only the SPI line is up and kept, but the unit is not a slave
   a_spi_wake_gate: assert property (@(posedge clock_i)
      disable iff (sys_rst_i)
      (mode_o == ST_DEEP_SLEEP && !spi_slave_i && !alarm_s && rst_pin_n_s
       && (wake_s & deep_keep_i) == (NP'(1) << `PMC_P_SPI))
      |=> mode_o == ST_DEEP_SLEEP) // [R10]
      else $error("SPI woke deep-sleep outside slave mode");

   // Only the USART line is up and kept, but no wake mode is selected
   a_usart_wake_gate: assert property (@(posedge clock_i)
      disable iff (sys_rst_i)
      (mode_o == ST_DEEP_SLEEP && !usart_sync_slave_i && !usart_32k_i
       && !alarm_s && rst_pin_n_s
       && (wake_s & deep_keep_i) == (NP'(1) << `PMC_P_USART))
      |=> mode_o == ST_DEEP_SLEEP) // [R9]
      else $error("USART woke deep-sleep outside its wake modes");

   a_pd_exit_only: assert property (@(posedge clock_i)
      disable iff (sys_rst_i)
      (mode_o == ST_POWER_DOWN && !alarm_s && rst_pin_n_s)
      |=> mode_o == ST_POWER_DOWN && !core_pwr_en_o
      && pin_tristate_o) // [R13]
      else $error("power-down left without reset pin or alarm");

   a_pd_domains: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      mode_o == ST_POWER_DOWN |-> !retain_o
      && periph_pwr_en_o == (NP'(1) << `PMC_P_RTC)) // [R12]
      else $error("power-down domains not as required");

   a_pd_reset_seq: assert property (@(posedge clock_i)
      disable iff (sys_rst_i)
      (mode_o == ST_POWER_DOWN && alarm_s && rst_pin_n_s)
      |=> chip_reset_o && mode_o == ST_RESET_SEQ) // [R16]
      else $error("power-down wake skipped the reset sequence");

   a_alarm_request: assert property (@(posedge clock_i)
      disable iff (sys_rst_i)
      $rose(alarm_s) |=> rtc_wake_req_o) // [R14]
      else $error("alarm flag raised no wake request");
endmodule

//--- rtl/power_mode_params.svh
// Constants for the power mode controller: indices, encodings, timing.
// What this block does
// R1 - Active: software switches peripheral clocks and power
// R2 - Sleep stops processor clock until reset or interrupt
// R3 - Sleep: clocked peripherals run, their interrupts wake
// R4 - Sleep and deep-sleep retain state, hold pins static
// R5 - Deep-sleep gates processor, main, peripheral clocks; FRO
// R6 - Deep-sleep puts flash into standby
// R7 - Deep-sleep: analog off unless kept as wake source
// R8 - Deep-sleep: listed blocks and oscillators may stay running
// R9 - Deep-sleep USART unclocked, wakes in sync-slave/32k mode
// R10 - Deep-sleep SPI, I2C unclocked, wake as slaves
// R11 - DMA active in sleep, limited in deep-sleep
// R12 - Power-down: only RTC domain and reset pin powered
// R13 - Power-down exits only on reset pin or alarm
// R14 - RTC one-hertz alarm flag raises chip wake request
// R15 - Power-down loses contents, functional pins high-impedance
// R16 - Waking from power-down runs full chip reset
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH

// Peripheral slots that may stay powered in deep-sleep
`define PMC_P_PIN_INT 0
`define PMC_P_GROUP_INT 1
`define PMC_P_USB 2
`define PMC_P_SPI 3
`define PMC_P_I2C 4
`define PMC_P_USART 5
`define PMC_P_WDOG 6
`define PMC_P_RTC 7
`define PMC_P_UTICK 8
`define PMC_P_BROWNOUT 9
`define PMC_NUM_PERIPH 10

// Analog slots: oscillators and detector supplies
`define PMC_A_RTC_OSC 0
`define PMC_A_WDT_OSC 1
`define PMC_A_BROWNOUT 2
`define PMC_NUM_ANALOG 3

// Requested mode codes from the power API
`define PMC_REQ_SLEEP 2'h1
`define PMC_REQ_DEEP_SLEEP 2'h2
`define PMC_REQ_POWER_DOWN 2'h3

// Chip reset sequence length
`define PMC_CLK_MHZ 40
`define PMC_RST_TIME_NS 500
`define PMC_RST_CYCLES ((`PMC_RST_TIME_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_CNT_W 8

`endif

//--- rtl/power_mode_pkg.sv
// Types shared by the power mode controller files.
package power_mode_pkg;

   // Power state of the chip, binary coded
   typedef enum logic [2:0]
   {
      ST_ACTIVE = 3'h0,
      ST_SLEEP = 3'h1,
      ST_DEEP_SLEEP = 3'h2,
      ST_POWER_DOWN = 3'h3,
      ST_RESET_SEQ = 3'h4
   } pmc_state_e;

endpackage

//--- rtl/pin_sync.sv
// Three-stage synchroniser with agreement filter for one async input.
`timescale 1ns/1ps
module pin_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic async_i,
   output logic sync_o
);
   // Stages two and three are compared; stage one feeds stage two only
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } sync_s;

   sync_s cur_q;
   sync_s nxt_d;

   // Shift and accept a level once the two late stages agree
   always_comb
   begin
      nxt_d = cur_q;
      nxt_d.s1 = async_i;
      nxt_d.s2 = cur_q.s1;
      nxt_d.s3 = cur_q.s2;
      if (cur_q.s2 == cur_q.s3)
      begin
         nxt_d.out = cur_q.s3;
      end
   end

   // State register
   always_ff @(posedge clock_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cur_q <= {4{RESET_VAL}};
      end
      else
      begin
         cur_q <= nxt_d;
      end
   end

   assign sync_o = cur_q.out;
endmodule

//--- test/wake_source_model.sv
// Partner model of the wake side: interrupt, wake lines, alarm and pin.
`timescale 1ns/1ps
module wake_source_model #(
   parameter int NP = 10
) (
   input wire logic clock_i,
   output logic irq_o,
   output logic [NP-1:0] wake_src_o,
   output logic rtc_alarm_flag_o,
   output logic reset_pin_n_o
);
   ///////////////////////////////////////////////////////////////////////
   // Idle levels: no request, reset pin released to its pull-up level
   initial
   begin
      irq_o = 1'b0;
      wake_src_o = '0;
      rtc_alarm_flag_o = 1'b0;
      reset_pin_n_o = 1'b1;
   end

   ///////////////////////////////////////////////////////////////////////
   // Levels change just after an edge; callers hold all but irq_o >= 4 cycles
   // so the three-stage synchronisers always see an agreed value
   task automatic drive(input int sel, input int idx, input logic val);
      @(posedge clock_i);
      #2;
      case (sel)
         0: irq_o = val; // Interrupt request
         1: wake_src_o[idx] = val; // Unit wake request
         2: rtc_alarm_flag_o = val; // One-hertz alarm flag
         default: reset_pin_n_o = val; // Reset pin, low asserted
      endcase
   endtask
endmodule

//--- test/power_mode_controller_bench.sv
// Self-checking bench for the power mode controller.
`timescale 1ns/1ps
`include "power_mode_params.svh"
module power_mode_controller_bench import power_mode_pkg::*;;
   localparam int NP = `PMC_NUM_PERIPH;
   localparam int NA = `PMC_NUM_ANALOG;
   localparam int RC = `PMC_RST_CYCLES;
   logic clock_i, sys_rst_i, enter_i; // Clock, reset, entry pulse
   logic [1:0] mode_req_i;
   logic [NP-1:0] pclk_i, ppwr_i, keep_i; // Software enables
   logic [NA-1:0] aen_i, akeep_i;
   logic fro_keep_i, dma_deep_i, u_sync_i, u_32k_i, spi_sl_i, i2c_sl_i;
   logic irq_i, alarm_i, rst_pin_n_i;
   logic [NP-1:0] wake_i;
   pmc_state_e mode_o;
   logic cpu_o, main_o, fro_o, flash_sb_o, dma_o, retain_o, hold_o;
   logic tri_o, core_o, chip_rst_o, rtc_req_o;
   logic [NP-1:0] pclk_o, ppwr_o;
   logic [NA-1:0] apwr_o;
   int miscompares, num_checks;

   ///////////////////////////////////////////////////////////////////////
   // Design and wake-side partner
   power_mode_controller dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .enter_i(enter_i), .mode_req_i(mode_req_i), .irq_i(irq_i),
      .periph_clk_en_i(pclk_i), .periph_pwr_en_i(ppwr_i),
      .analog_en_i(aen_i), .deep_keep_i(keep_i), .analog_keep_i(akeep_i),
      .fro_keep_i(fro_keep_i), .dma_deep_en_i(dma_deep_i),
      .usart_sync_slave_i(u_sync_i), .usart_32k_i(u_32k_i),
      .spi_slave_i(spi_sl_i), .i2c_slave_i(i2c_sl_i), .wake_src_i(wake_i),
      .rtc_alarm_flag_i(alarm_i), .reset_pin_n_i(rst_pin_n_i),
      .mode_o(mode_o), .cpu_clk_en_o(cpu_o), .main_clk_en_o(main_o),
      .periph_clk_en_o(pclk_o), .periph_pwr_en_o(ppwr_o),
      .analog_pwr_en_o(apwr_o), .fro_en_o(fro_o),
      .flash_standby_o(flash_sb_o), .dma_en_o(dma_o), .retain_o(retain_o),
      .pin_hold_o(hold_o), .pin_tristate_o(tri_o), .core_pwr_en_o(core_o),
      .chip_reset_o(chip_rst_o), .rtc_wake_req_o(rtc_req_o));
   wake_source_model #(.NP(NP)) partner (.clock_i(clock_i),
      .irq_o(irq_i), .wake_src_o(wake_i), .rtc_alarm_flag_o(alarm_i),
      .reset_pin_n_o(rst_pin_n_i));

   ///////////////////////////////////////////////////////////////////////
   // Shared helpers; all bench activity sits 2 ns after a rising edge
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge clock_i);
         #2;
      end
   endtask
   task automatic enter(input logic [1:0] m);
      enter_i = 1'b1;
      mode_req_i = m;
      step(1);
      enter_i = 1'b0;
   endtask
   // Bounded wait, so a missing transition cannot hang the run
   task automatic wait_mode(input pmc_state_e m, input int lim,
                            output int n);
      n = 0;
      while (mode_o !== m && n < lim)
      begin
         step(1);
         n++;
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   ///////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_sleep();
      check(pclk_o, pclk_i);
      check(ppwr_o, ppwr_i);
      check(apwr_o, aen_i);
      enter(2'h1);
      check({cpu_o, main_o, hold_o, retain_o, dma_o}, 5'h0F);
      pclk_i = 10'h0F0;
      step(2);
      check(pclk_o, 10'h0F0);
      check(dma_o, 1'b1);
      partner.drive(1, `PMC_P_SPI, 1'b1);
      step(6);
      check(mode_o, ST_SLEEP);
      partner.drive(1, `PMC_P_SPI, 1'b0);
      partner.drive(0, 0, 1'b1);
      step(1);
      check({mode_o, cpu_o, hold_o}, {ST_ACTIVE, 2'h2});
      partner.drive(0, 0, 1'b0);
      $display("test sleep done");
   endtask

   // Unit wake in deep-sleep is refused until its mode qualifies
   task automatic t_deep(input int unit, input logic fro);
      int n;
      fro_keep_i = fro;
      enter(2'h2);
      check({cpu_o, main_o, pclk_o}, '0);
      check(fro_o, fro);
      check(flash_sb_o, 1'b1);
      check(apwr_o, akeep_i);
      check(ppwr_o, ppwr_i & keep_i);
      check({retain_o, hold_o, dma_o}, 3'h7);
      partner.drive(0, 0, 1'b1);
      partner.drive(1, unit, 1'b1);
      step(8);
      check(mode_o, ST_DEEP_SLEEP);
      if (unit == `PMC_P_USART && fro)
         u_sync_i = 1'b1;
      else if (unit == `PMC_P_USART)
         u_32k_i = 1'b1;
      else if (unit == `PMC_P_I2C)
         i2c_sl_i = 1'b1;
      else
         spi_sl_i = 1'b1;
      wait_mode(ST_ACTIVE, 8, n);
      check(mode_o, ST_ACTIVE);
      partner.drive(1, unit, 1'b0);
      partner.drive(0, 0, 1'b0);
      {u_sync_i, u_32k_i, spi_sl_i, i2c_sl_i} = 4'h0;
      $display("test deep-sleep done");
   endtask

   task automatic t_down(input logic by_pin);
      int n;
      enter(2'h3);
      check({tri_o, core_o, retain_o, cpu_o}, 4'h8);
      check(ppwr_o, 10'h001 << `PMC_P_RTC);
      partner.drive(0, 0, 1'b1);
      partner.drive(1, `PMC_P_SPI, 1'b1);
      step(8);
      check(mode_o, ST_POWER_DOWN);
      partner.drive(0, 0, 1'b0);
      partner.drive(1, `PMC_P_SPI, 1'b0);
      partner.drive(by_pin ? 3 : 2, 0, !by_pin);
      wait_mode(ST_RESET_SEQ, 8, n);
      check({mode_o, chip_rst_o}, {ST_RESET_SEQ, 1'b1});
      if (!by_pin)
         check(rtc_req_o, 1'b1);
      // A pin held low keeps the sequence from counting
      if (by_pin)
      begin
         step(30);
         check(mode_o, ST_RESET_SEQ);
      end
      partner.drive(by_pin ? 3 : 2, 0, by_pin);
      wait_mode(ST_ACTIVE, 30, n);
      if (!by_pin)
         check(n, RC - 1);
      check({mode_o, chip_rst_o, cpu_o}, {ST_ACTIVE, 2'h1});
      $display("test power-down done");
   endtask

   ///////////////////////////////////////////////////////////////////////
   // Clock, watchdog and main sequence
   initial
   begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   initial
   begin
      #(25 * 3000);
      miscompares++;
      summarize();
   end
   initial
   begin
      int n;
      {sys_rst_i, enter_i, mode_req_i} = 4'h8;
      {pclk_i, ppwr_i, keep_i} = {10'h2A5, 10'h15A, 10'h0B8};
      {aen_i, akeep_i} = {3'h5, 3'h2};
      {fro_keep_i, dma_deep_i, u_sync_i, u_32k_i} = 4'h4;
      {spi_sl_i, i2c_sl_i} = 2'h0;
      repeat (5) @(posedge clock_i);
      #2;
      check({mode_o, chip_rst_o, tri_o, core_o}, {ST_RESET_SEQ, 3'h7});
      sys_rst_i = 1'b0;
      wait_mode(ST_ACTIVE, 40, n);
      check(n >= RC - 1 && n <= RC + 2, 1'b1);
      t_sleep();
      t_deep(`PMC_P_USART, 1'b0);
      t_deep(`PMC_P_USART, 1'b1);
      t_deep(`PMC_P_SPI, 1'b1);
      t_deep(`PMC_P_I2C, 1'b0);
      t_down(1'b0);
      t_down(1'b1);
      summarize();
   end
endmodule
